// File: logic/gain_control_config_regs.v
/*
 gain control configuration registers behind the two-wire control
 port, with decoded dB settings and the run-time gain change stepper.
 assumes scl and sda come from pins; sda is open drain, pulled up
 outside; the remaining inputs come from logic on clk.
*/
`include "gain_cfg_defs.vh"

module gain_control_config_regs #(
	parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
	// clock and reset
	input wire clk,
	input wire srst,
	// two-wire control port
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output reg sda_oe,
	// signal-path control from neighbouring registers
	input wire compression_enable,
	input wire enhancer_or_autogain_select,
	input wire impedance_20k,
	input wire [6:0] channel_gain_req,
	input wire zero_cross,
	// register fields
	output wire [3:0] enhancer_trigger_level,
	output wire [3:0] enhancer_max_gain,
	output wire [3:0] autogain_target_level,
	output wire [3:0] autogain_max_gain,
	output wire [1:0] runtime_gain_change_mode,
	// decoded settings in dB, trigger and target signed, max gain unsigned
	output reg signed [7:0] trigger_db,
	output reg signed [7:0] target_db,
	output reg [7:0] active_max_gain_db,
	output reg range_enhancer_active,
	output reg automatic_gain_loop_active,
	// applied channel gain, 0.5 dB units
	output wire [6:0] applied_gain,
	output wire gain_ramping
);

	// ----------------------------------------
	// control port states
	// ----------------------------------------
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_ADDR = 4'h1;
	localparam [3:0] S_ADDR_ACK = 4'h2;
	localparam [3:0] S_PTR = 4'h3;
	localparam [3:0] S_PTR_ACK = 4'h4;
	localparam [3:0] S_WR = 4'h5;
	localparam [3:0] S_WR_ACK = 4'h6;
	localparam [3:0] S_RD = 4'h7;
	localparam [3:0] S_RD_ACK = 4'h8;

	// register storage
	reg [7:0] range_enhancer_cfg;
	reg [7:0] auto_gain_target_cfg;
	reg [2:0] gain_change_hi;
	// reset image of the gain change register, only bits 7-5 stored
	wire [7:0] gain_change_rst = `RST_GAIN_CHANGE_CFG;
	// pin synchronisers, stage one feeds stage two only
	reg scl_s1, scl_s2, scl_d;
	reg sda_s1, sda_s2, sda_d;
	// port engine
	reg [3:0] state;
	reg [3:0] bit_cnt;
	reg [7:0] shreg;
	reg [7:0] ptr;
	reg rw;
	reg nack;

	// edge and condition detection on synchronised pins
	wire scl_rise = scl_s2 & ~scl_d;
	wire scl_fall = ~scl_s2 & scl_d;
	wire start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
	wire stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;

	// the pin is only ever pulled low
	assign sda_out = 1'b0;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// register read mux, unmapped reads as zero
	function [7:0] read_reg;
		input [7:0] a;
		begin
			case (a)
			`ADDR_ENHANCER_CFG: read_reg = range_enhancer_cfg;
			`ADDR_AUTOGAIN_CFG: read_reg = auto_gain_target_cfg;
			`ADDR_GAIN_CHANGE_CFG: read_reg = {gain_change_hi, 5'h00};
			default: read_reg = 8'h00;
			endcase
		end
	endfunction

	// linear code to dB: base plus step per code
	function [7:0] lin_db;
		input [3:0] code;
		input [7:0] base;
		input [7:0] step;
		// full product, cut to eight bits on purpose
		reg [11:0] prod;
		begin
			prod = code * step;
			lin_db = base + prod[7:0];
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
		end
	end

	// ----------------------------------------
	// control port engine and register writes
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			state <= S_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			ptr <= 8'h00;
			rw <= 1'b0;
			nack <= 1'b0;
			range_enhancer_cfg <= `RST_ENHANCER_CFG;
			auto_gain_target_cfg <= `RST_AUTOGAIN_CFG;
			gain_change_hi <= gain_change_rst[7:5];
		end else if (start_cond) begin
			// start or repeated start restarts addressing
			state <= S_ADDR;
			bit_cnt <= 4'h0;
		end else if (stop_cond) begin
			state <= S_IDLE;
		end else if (scl_rise) begin
			// sample on the rising clock
			case (state)
			S_ADDR, S_PTR, S_WR: begin
				shreg <= {shreg[6:0], sda_s2};
				bit_cnt <= bit_cnt + 4'h1;
			end
			S_RD: begin
				bit_cnt <= bit_cnt + 4'h1;
			end
			S_RD_ACK: begin
				// high means the master wants no more
				nack <= sda_s2;
			end
			default: begin
			end
			endcase
		end else if (scl_fall) begin
			// change state while the clock is low
			case (state)
			S_ADDR: begin
				if (bit_cnt == 4'h8) begin
					if (shreg[7:1] == DEV_ADDR) begin
						state <= S_ADDR_ACK;
						rw <= shreg[0];
					end else begin
						// not ours: stay off the bus until next start
						state <= S_IDLE;
					end
				end
			end
			S_ADDR_ACK: begin
				bit_cnt <= 4'h0;
				if (rw) begin
					state <= S_RD;
					shreg <= read_reg(ptr);
					ptr <= ptr + 8'h01;
				end else begin
					state <= S_PTR;
				end
			end
			S_PTR: begin
				if (bit_cnt == 4'h8) begin
					ptr <= shreg;
					state <= S_PTR_ACK;
				end
			end
			S_PTR_ACK, S_WR_ACK: begin
				bit_cnt <= 4'h0;
				state <= S_WR;
			end
			S_WR: begin
				if (bit_cnt == 4'h8) begin
					state <= S_WR_ACK;
					ptr <= ptr + 8'h01;
					// writes to unmapped offsets are acked and dropped
					case (ptr)
					`ADDR_ENHANCER_CFG: range_enhancer_cfg <= shreg;
					`ADDR_AUTOGAIN_CFG: auto_gain_target_cfg <= shreg;
					`ADDR_GAIN_CHANGE_CFG: gain_change_hi <= shreg[7:5];
					default: begin
					end
					endcase
				end
			end
			S_RD: begin
				if (bit_cnt == 4'h8) begin
					state <= S_RD_ACK;
				end else begin
					shreg <= {shreg[6:0], 1'b0};
				end
			end
			S_RD_ACK: begin
				bit_cnt <= 4'h0;
				if (nack) begin
					state <= S_IDLE;
				end else begin
					// sequential read continues at the next offset
					state <= S_RD;
					shreg <= read_reg(ptr);
					ptr <= ptr + 8'h01;
				end
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------
	// sda drive, registered to avoid glitches
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			sda_oe <= 1'b0;
		end else begin
			case (state)
			S_ADDR_ACK, S_PTR_ACK, S_WR_ACK: sda_oe <= 1'b1;
			S_RD: sda_oe <= ~shreg[7];
			default: sda_oe <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// field outputs
	// ----------------------------------------
	// threshold upper nibble
	assign enhancer_trigger_level =
		range_enhancer_cfg[`LEVEL_HI:`LEVEL_LO];
	assign enhancer_max_gain = range_enhancer_cfg[`MAXG_HI:`MAXG_LO];
	assign autogain_target_level =
		auto_gain_target_cfg[`LEVEL_HI:`LEVEL_LO];
	assign autogain_max_gain = auto_gain_target_cfg[`MAXG_HI:`MAXG_LO];
	assign runtime_gain_change_mode = gain_change_hi[2:1];

	// ----------------------------------------
	// decoded settings
	// ----------------------------------------
	// reserved codes decode on the same line; software keeps clear of them
	always @(posedge clk) begin
		if (srst) begin
			trigger_db <= 8'sh00;
			target_db <= 8'sh00;
			active_max_gain_db <= 8'h00;
			range_enhancer_active <= 1'b0;
			automatic_gain_loop_active <= 1'b0;
		end else begin
			// 12 dB less 6 dB per code
			trigger_db <= -$signed(lin_db(enhancer_trigger_level,
				8'h0C, 8'h06));
			// 6 dB less 2 dB per code
			target_db <= -$signed(lin_db(autogain_target_level,
				8'h06, 8'h02));
			range_enhancer_active <= ~compression_enable &
				~enhancer_or_autogain_select;
			automatic_gain_loop_active <= ~compression_enable &
				enhancer_or_autogain_select;
			if (enhancer_or_autogain_select) begin
				// 3 dB per code from 3 dB
				active_max_gain_db <= lin_db(autogain_max_gain,
					8'h03, 8'h03);
			end else begin
				// 2 dB per code from 2 dB
				active_max_gain_db <= lin_db(enhancer_max_gain,
					8'h02, 8'h02);
			end
		end
	end

	// ----------------------------------------
	// run-time gain change
	// ----------------------------------------
	gain_stepper u_stepper (
		.clk(clk),
		.srst(srst),
		.mode(runtime_gain_change_mode),
		.impedance_20k(impedance_20k),
		.target_gain(channel_gain_req),
		.zero_cross(zero_cross),
		.applied_gain(applied_gain),
		.ramping(gain_ramping)
	);

endmodule // gain_control_config_regs

// File: logic/gain_cfg_defs.vh
/*
 gain control configuration constants: register offsets, reset values,
 field positions and soft-step timing counts.
 assumes the includer runs on one 100 MHz control clock.
*/
// What this block does
// - trigger threshold upper nibble, reset 0111b, -12..-102 dB
// - enhancer max gain lower nibble, reset 1011b
// - target level upper nibble, reset 1110b, -6..-36 dB
// - autogain max gain lower nibble, reset 0111b
// - autogain config at 0x70, reset 0xE7
// - mode 0 applies channel gain immediately
// - mode 1 reduced artifacts, no stepping
// - mode 2 steps 0.5 dB per 20 us
// - mode 3 steps 0.5 dB per 40 us
// - bit 5 writable reserved, bits 4-0 read zero
// - gain change config at 0x71, resets zero
// - select bit picks enhancer or autogain
`ifndef GAIN_CFG_DEFS_VH
`define GAIN_CFG_DEFS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define ADDR_ENHANCER_CFG 8'h6D
`define ADDR_AUTOGAIN_CFG 8'h70
`define ADDR_GAIN_CHANGE_CFG 8'h71
`define RST_ENHANCER_CFG 8'h7B
`define RST_AUTOGAIN_CFG 8'hE7
`define RST_GAIN_CHANGE_CFG 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define LEVEL_HI 7
`define LEVEL_LO 4
`define MAXG_HI 3
`define MAXG_LO 0
`define MODE_HI 7
`define MODE_LO 6
`define RSVD_BIT 5
`define GAIN_CHANGE_WMASK 8'hE0

// ----------------------------------------
// run-time gain change modes
// ----------------------------------------
`define MODE_IMMEDIATE 2'h0
`define MODE_REDUCED 2'h1
`define MODE_STEP_FAST 2'h2
`define MODE_STEP_SLOW 2'h3

// ----------------------------------------
// timing and gain ceilings (gain in 0.5 dB units)
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define STEP_FAST_US 20
`define STEP_SLOW_US 40
`define STEP_FAST_CYC ((`STEP_FAST_US * 1000) / `CLK_PERIOD_NS)
`define STEP_SLOW_CYC ((`STEP_SLOW_US * 1000) / `CLK_PERIOD_NS)
`define CEIL_10K 7'h3C
`define CEIL_20K 7'h30

// ----------------------------------------
// control port
// ----------------------------------------
`define DEV_ADDR_DEFAULT 7'h2A

`endif

// File: logic/gain_stepper.v
/*
 applies a requested channel gain according to the run-time gain
 change mode: at once, at a zero crossing, or ramped in half-dB steps.
 assumes target gain and zero_cross come from logic on the same clock.
*/
`include "gain_cfg_defs.vh"

module gain_stepper (
	// clock and reset
	input wire clk,
	input wire srst,
	// configuration
	input wire [1:0] mode,
	input wire impedance_20k,
	// requested gain, 0.5 dB units
	input wire [6:0] target_gain,
	input wire zero_cross,
	// applied gain
	output reg [6:0] applied_gain,
	output reg ramping
);

	// step timer, wide enough for the slow period
	reg [11:0] tick_cnt;
	// ramp ceiling per impedance mode
	wire [6:0] ceil = impedance_20k ? `CEIL_20K : `CEIL_10K;
	// clamped ramp goal
	wire [6:0] ramp_goal = (target_gain > ceil) ? ceil : target_gain;
	// step periods cut to the timer width; 4000 still fits 12 bits
	wire [31:0] slow_cyc = `STEP_SLOW_CYC;
	wire [31:0] fast_cyc = `STEP_FAST_CYC;
	// step period select
	wire [11:0] period = (mode == `MODE_STEP_SLOW) ?
		slow_cyc[11:0] : fast_cyc[11:0];

	// ----------------------------------------
	// gain update
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			applied_gain <= 7'h00;
			tick_cnt <= 12'h000;
			ramping <= 1'b0;
		end else begin
			case (mode)
			`MODE_IMMEDIATE: begin
				applied_gain <= target_gain;
				tick_cnt <= 12'h000;
				ramping <= 1'b0;
			end
			`MODE_REDUCED: begin
				// jump only at a zero crossing to hide the step
				if (zero_cross) begin
					applied_gain <= target_gain;
				end
				tick_cnt <= 12'h000;
				ramping <= 1'b0;
			end
			default: begin
				if (applied_gain == ramp_goal) begin
					tick_cnt <= 12'h000;
					ramping <= 1'b0;
				end else if (tick_cnt >= period - 12'h001) begin
					tick_cnt <= 12'h000;
					ramping <= 1'b1;
					// one 0.5 dB step toward the goal
					if (applied_gain < ramp_goal) begin
						applied_gain <= applied_gain + 7'h01;
					end else begin
						applied_gain <= applied_gain - 7'h01;
					end
				end else begin
					tick_cnt <= tick_cnt + 12'h001;
					ramping <= 1'b1;
				end
			end
			endcase
		end
	end

endmodule // gain_stepper

// File: sim/gain_cfg_sva.sv
/*
 checker for the gain config registers: reset load, decode, select
 and the way a requested gain is applied.
 assumes a bind to the top module, one clock, synchronous reset.
*/
`include "gain_cfg_defs.vh"

module gain_cfg_sva (
	// clock and reset
	input wire clk,
	input wire srst,
	// control inputs
	input wire compression_enable,
	input wire enhancer_or_autogain_select,
	input wire [6:0] channel_gain_req,
	input wire zero_cross,
	// register fields
	input wire [3:0] enhancer_trigger_level,
	input wire [3:0] enhancer_max_gain,
	input wire [3:0] autogain_target_level,
	input wire [3:0] autogain_max_gain,
	input wire [1:0] runtime_gain_change_mode,
	// decoded and applied outputs
	input wire signed [7:0] trigger_db,
	input wire signed [7:0] target_db,
	input wire [7:0] active_max_gain_db,
	input wire range_enhancer_active,
	input wire automatic_gain_loop_active,
	input wire [6:0] applied_gain
);
	// ---
	// helpers
	// ---
	// edges since reset; decode lags its field by a cycle
	reg [1:0] up;
	always @(posedge clk) begin
		if (srst) up <= 2'h0;
		else if (up != 2'h3) up <= up + 2'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// a zero crossing while in the reduced-artifact mode
	sequence s_zc;
		runtime_gain_change_mode == 2'h1 && zero_cross;
	endsequence
	// ramp mode held long enough that no mode jump is in flight
	sequence s_ramp;
		runtime_gain_change_mode[1] [*3];
	endsequence
	// ---
	// assertions
	// ---
	a_reset_load: assert property (
		$past(srst) |-> {enhancer_trigger_level, enhancer_max_gain,
		autogain_target_level, autogain_max_gain, runtime_gain_change_mode}
		== {`RST_ENHANCER_CFG, `RST_AUTOGAIN_CFG, 2'h0})
		else $error("fields not at reset values");
	a_trig_decode: assert property (
		up == 2'h3 |-> trigger_db ==
		8'd244 - 8'd6 * $past(enhancer_trigger_level))
		else $error("trigger level decode wrong");
	a_target_decode: assert property (
		up == 2'h3 |-> target_db ==
		8'd250 - 8'd2 * $past(autogain_target_level))
		else $error("target level decode wrong");
	a_max_select: assert property (
		up == 2'h3 |-> active_max_gain_db ==
		($past(enhancer_or_autogain_select) ?
		8'd3 + 8'd3 * $past(autogain_max_gain) :
		8'd2 + 8'd2 * $past(enhancer_max_gain)))
		else $error("max gain decode wrong");
	a_enh_active: assert property (
		up == 2'h3 |-> range_enhancer_active ==
		$past(!compression_enable && !enhancer_or_autogain_select))
		else $error("enhancer active wrong");
	a_loop_active: assert property (
		up == 2'h3 |-> automatic_gain_loop_active ==
		$past(!compression_enable && enhancer_or_autogain_select))
		else $error("gain loop active wrong");
	a_mode0_apply: assert property (
		runtime_gain_change_mode == 2'h0 |=>
		applied_gain == $past(channel_gain_req))
		else $error("immediate gain not applied");
	a_zc_apply: assert property (
		s_zc |=> applied_gain == $past(channel_gain_req))
		else $error("gain not applied at crossing");
	a_mode1_hold: assert property (
		runtime_gain_change_mode == 2'h1 && !zero_cross |=>
		$stable(applied_gain))
		else $error("gain moved between crossings");
	a_ramp_unit: assert property (
		s_ramp |-> applied_gain == $past(applied_gain) ||
		applied_gain == $past(applied_gain) + 7'h1 ||
		applied_gain == $past(applied_gain) - 7'h1)
		else $error("ramp step larger than half dB");
endmodule // gain_cfg_sva

bind gain_control_config_regs gain_cfg_sva gain_cfg_sva_inst (.clk, .srst,
	.compression_enable, .enhancer_or_autogain_select, .channel_gain_req,
	.zero_cross, .enhancer_trigger_level, .enhancer_max_gain,
	.autogain_target_level, .autogain_max_gain, .runtime_gain_change_mode,
	.trigger_db, .target_db, .active_max_gain_db, .range_enhancer_active,
	.automatic_gain_loop_active, .applied_gain);

// File: sim/tb_top.sv
/*
 bench for the gain config registers: two-wire port tasks, one task
 per scenario. assumes the header on the include path, 100 MHz clock.
*/
`include "gain_cfg_defs.vh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
	bad_count++; $display("Error %s exp %h got %h", n, e, s); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ---
	// stimulus and wires
	// ---
	reg clk = 0, srst = 1, scl_in = 1, sdm = 1, compression_enable = 0;
	reg enhancer_or_autogain_select = 0, impedance_20k = 0, zero_cross = 0;
	reg [6:0] channel_gain_req = 0;
	wire sda_out, sda_oe;
	wire [3:0] enhancer_trigger_level, enhancer_max_gain;
	wire [3:0] autogain_target_level, autogain_max_gain;
	wire [1:0] runtime_gain_change_mode;
	wire signed [7:0] trigger_db, target_db;
	wire [7:0] active_max_gain_db;
	wire range_enhancer_active, automatic_gain_loop_active, gain_ramping;
	wire [6:0] applied_gain;
	// pulled-up line: the device can only pull it low
	wire sda_in = sda_oe ? (sdm & sda_out) : sdm;
	int bad_count = 0, n_checks = 0;
	reg [7:0] v; // read-back byte

	gain_control_config_regs gain_control_config_regs_inst (.clk, .srst,
		.scl_in, .sda_in, .sda_out, .sda_oe, .compression_enable,
		.enhancer_or_autogain_select, .impedance_20k, .channel_gain_req,
		.zero_cross, .enhancer_trigger_level, .enhancer_max_gain,
		.autogain_target_level, .autogain_max_gain,
		.runtime_gain_change_mode, .trigger_db, .target_db,
		.active_max_gain_db, .range_enhancer_active,
		.automatic_gain_loop_active, .applied_gain, .gain_ramping);

	initial forever #5 clk = ~clk;
	// ---
	// port tasks
	// ---
	// inputs move 1 ns after an edge; scl halves of 10 clocks each
	task tick(input int n); repeat (n) @(posedge clk); #1; endtask
	task bw(input bit b);
		sdm = b; tick(8); scl_in = 1; tick(10); scl_in = 0; tick(2);
	endtask
	// sampled mid-high, long after the device answers
	task br(output bit b);
		sdm = 1; tick(8); scl_in = 1; tick(5); b = sda_in; tick(5);
		scl_in = 0; tick(2);
	endtask
	task wb(input [7:0] d);
		bit a;
		for (int i = 7; i >= 0; i--) bw(d[i]);
		br(a);
		`CHK("ack", 1'b0, a);
	endtask
	task st;
		sdm = 1; tick(8); scl_in = 1; tick(10); sdm = 0; tick(10);
		scl_in = 0; tick(2);
	endtask
	task sp; sdm = 0; tick(8); scl_in = 1; tick(10); sdm = 1; tick(10); endtask
	task wr(input [7:0] a, input [7:0] d);
		st; wb({`DEV_ADDR_DEFAULT, 1'b0}); wb(a); wb(d); sp;
	endtask
	// pointer write, repeated start, one byte, master nack
	task rd(input [7:0] a, output [7:0] d);
		bit b;
		st; wb({`DEV_ADDR_DEFAULT, 1'b0}); wb(a);
		st; wb({`DEV_ADDR_DEFAULT, 1'b1});
		for (int i = 7; i >= 0; i--) begin
			br(b);
			d[i] = b;
		end
		bw(1); sp;
	endtask
	// ---
	// scenarios
	// ---
	task t_reset;
		rd(8'h6D, v); `CHK("enh_cfg", 8'h7B, v);
		rd(8'h70, v); `CHK("agc_cfg", 8'hE7, v);
		rd(8'h71, v); `CHK("chg_cfg", 8'h00, v);
		rd(8'h72, v); `CHK("unmapped", 8'h00, v);
		`CHK("trig_db", 8'hCA, trigger_db);
		`CHK("target_db", 8'hDE, target_db);
		`CHK("max_db", 8'h18, active_max_gain_db);
		`CHK("agc_max", 4'h7, autogain_max_gain);
		$display("t_reset done");
	endtask
	// intermediate codes land on the linear step
	task t_fields;
		wr(8'h6D, 8'h4C); wr(8'h70, 8'h5D); tick(3);
		`CHK("trig_db", 8'hDC, trigger_db);
		`CHK("max_db", 8'h1A, active_max_gain_db);
		`CHK("target_db", 8'hF0, target_db);
		enhancer_or_autogain_select = 1; tick(3);
		`CHK("max_db", 8'h2A, active_max_gain_db);
		rd(8'h70, v); `CHK("agc_cfg", 8'h5D, v);
		$display("t_fields done");
	endtask
	task t_select;
		for (int i = 0; i < 4; i++) begin
			{compression_enable, enhancer_or_autogain_select} = i; tick(3);
			`CHK("enh_on", i == 0, range_enhancer_active);
			`CHK("agc_on", i == 1, automatic_gain_loop_active);
		end
		$display("t_select done");
	endtask
	// low bits read zero; software keeps the reserved bit clear
	task t_gcfg;
		wr(8'h71, 8'hDF); rd(8'h71, v);
		`CHK("chg_cfg", 8'hC0, v);
		`CHK("mode", 2'h3, runtime_gain_change_mode);
		wr(8'h71, 8'h00);
		$display("t_gcfg done");
	endtask
	task t_apply;
		channel_gain_req = 7'h20; tick(2);
		`CHK("gain", 7'h20, applied_gain);
		wr(8'h71, 8'h40); channel_gain_req = 7'h10; tick(6);
		`CHK("gain", 7'h20, applied_gain);
		zero_cross = 1; tick(1); zero_cross = 0; tick(2);
		`CHK("gain", 7'h10, applied_gain);
		$display("t_apply done");
	endtask
	// step spacing and ceilings, both impedance modes
	task t_ramp;
		wr(8'h71, 8'h80); channel_gain_req = 7'h13; tick(3000);
		`CHK("mid", 1'b1, applied_gain > 7'h10 && applied_gain < 7'h13);
		tick(3100); `CHK("gain", 7'h13, applied_gain);
		`CHK("ramping", 1'b0, gain_ramping);
		wr(8'h71, 8'h00); channel_gain_req = 7'h40; tick(2);
		wr(8'h71, 8'h80); tick(8100);
		`CHK("ceil10k", `CEIL_10K, applied_gain);
		wr(8'h71, 8'h00); channel_gain_req = 7'h32; impedance_20k = 1;
		wr(8'h71, 8'h80); tick(4100);
		`CHK("ceil20k", `CEIL_20K, applied_gain);
		wr(8'h71, 8'hC0); impedance_20k = 0; channel_gain_req = 7'h33;
		tick(7000); `CHK("ramping", 1'b1, gain_ramping);
		tick(5100); `CHK("gain", 7'h33, applied_gain);
		$display("t_ramp done");
	endtask
	// ---
	// sequence and verdict
	// ---
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		#1 srst = 0;
		tick(2);
		t_reset; t_fields; t_select; t_gcfg; t_apply; t_ramp;
		close_out;
	end
	// tests need about 42k clocks; more than twice that means a hang
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		close_out;
	end
endmodule // tb_top
